// ### logic/adcctl_top.v
// ADC control and result registers behind an AHB-Lite slave port.
// Assumes a SAR analog core with trial-code input and comparator output,
// a port block that applies the pin enables and pull-ups, and LOW_VOLTAGE_RESET/LOW_VOLTAGE_DETECT
// enables from the supervisor on the same clock.
// Port requests and supervisor enables are synchronous to MCLK; only the
// comparator crosses from outside and is synchronised here.
`timescale 1ns/1ns
`include "adcctl_map.vh"
module adcctl_top (
  // Clock and reset
  input  wire        MCLK,
  input  wire        RST_N,
  // AHB-Lite slave
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output reg  [31:0] HRDATA,
  output wire        HREADYOUT,
  output wire        HRESP,
  // Analog core
  input  wire        ADC_COMP_IN,
  output wire [11:0] ADC_DAC_CODE,
  output wire        ADC_SAMPLE,
  output reg         ADC_CORE_RESET,
  output wire        ADC_POWER_DOWN,
  output reg  [3:0]  ADC_CH_SEL,
  output wire        REF_EXT_SEL,
  // Bandgap and supervisors
  input  wire        LVR_EN,
  input  wire        LVD_EN,
  output reg         BANDGAP_ON,
  // Port pins
  input  wire [7:0]  PULLUP_REQ,
  output wire [7:0]  PIN_ANALOG_EN,
  output reg  [7:0]  PULLUP_EN,
  // End of conversion request flag
  output wire        CONV_DONE_FLAG
);

  // Register state
  reg        start_reg;
  reg        busy_reg;
  reg        pdown_reg;
  reg        align_reg;
  reg [3:0]  chan_reg;
  reg        bgsel_reg;
  reg        bgen_reg;
  reg        refsel_reg;
  reg [2:0]  div_reg;
  reg [7:0]  pin_en_reg;
  reg        done_flag_reg;

  // Bus state
  reg        wr_pend_reg;
  reg        rd_pend_reg;
  reg [7:0]  addr_reg;
  reg [31:0] rd_next;

  // Comparator synchroniser
  reg        comp_s1_reg;
  reg        comp_s2_reg;
  reg        comp_s3_reg;
  reg        comp_reg;

  // Sequencer handshake
  // conv_go_reg is a one-cycle pulse on the start bit's falling write while pdown_reg is clear
  reg        conv_go_reg;
  wire       tick;
  wire       conv_done;
  wire [11:0] result;
  wire       comp_hi;

  wire       addr_take;
  wire       wr_a;
  wire       wr_st;
  wire [7:0] wbyte;
  wire       start_rise;
  wire       start_fall;
  wire       bg_in_use;

  // Formats one result byte for the chosen alignment
  // Alignment is applied on read, so changing it reformats the stored result
  function [7:0] fmt_byte;
    input [11:0] res;
    input        right;
    input        high;
    begin
      case ({right, high})
        2'b00:   fmt_byte = {res[3:0], 4'h0};
        2'b01:   fmt_byte = res[11:4];
        2'b10:   fmt_byte = res[7:0];
        2'b11:   fmt_byte = {4'h0, res[11:8]};
        default: fmt_byte = 8'h00;
      endcase
    end
  endfunction

  // Writes are zero-wait; a read waits one cycle so that a write just
  // before it is already visible, at the cost of one bus cycle.
  assign HREADYOUT = !rd_pend_reg;
  assign HRESP     = 1'b0;
  assign addr_take = HSEL && HREADY && HTRANS[1];
  assign wbyte     = HWDATA[7:0];
  assign wr_a      = wr_pend_reg && addr_reg == `ADCCTL_OFS_CTRL_A;
  assign wr_st     = wr_pend_reg && addr_reg == `ADCCTL_OFS_STATUS;
  assign start_rise = wr_a && wbyte[`ADCCTL_A_START] && !start_reg;
  assign start_fall = wr_a && !wbyte[`ADCCTL_A_START] && start_reg;

  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end else begin
      wr_pend_reg <= addr_take && HWRITE;
      rd_pend_reg <= addr_take && !HWRITE;
      if (addr_take) begin
        // Byte lanes and HSIZE are ignored; each register is the low byte of its word
        addr_reg <= {HADDR[7:2], 2'b00};
      end
    end
  end

  // Unmapped offsets read as zero
  // Upper read data bits are always zero; only bits 7:0 carry a register
  always @* begin
    rd_next = 32'h0000_0000;
    if (HADDR[31:8] == 24'h00_0000 || 1'b1) begin
      case (addr_reg)
        `ADCCTL_OFS_RES_LO: rd_next[7:0] = fmt_byte(result_hold(1'b0), align_reg, 1'b0);
        `ADCCTL_OFS_RES_HI: rd_next[7:0] = fmt_byte(result_hold(1'b0), align_reg, 1'b1);
        `ADCCTL_OFS_CTRL_A: rd_next[7:0] = {start_reg, busy_reg, pdown_reg, align_reg, chan_reg};
        `ADCCTL_OFS_CTRL_B: rd_next[7:0] = {bgsel_reg, bgen_reg, 1'b0, refsel_reg, 1'b0, div_reg};
        `ADCCTL_OFS_PIN_EN: rd_next[7:0] = pin_en_reg;
        `ADCCTL_OFS_STATUS: rd_next[`ADCCTL_S_DONE] = done_flag_reg;
        default:            rd_next = 32'h0000_0000;
      endcase
    end
  end

  // Identity of the stored result; kept as a function for the two byte views
  function [11:0] result_hold;
    input dummy;
    begin
      result_hold = result;
    end
  endfunction

  // Read data stays until the next read's data phase replaces it
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      HRDATA <= 32'h0000_0000;
    end else if (rd_pend_reg) begin
      HRDATA <= rd_next;
    end
  end

  // Control registers
  // The busy bit and the result offsets take no writes; start, power-down,
  // alignment and channel share one write so a start carries its settings.
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      start_reg  <= 1'b0;
      pdown_reg  <= 1'b1;
      align_reg  <= 1'b0;
      chan_reg   <= 4'h0;
      bgsel_reg  <= 1'b0;
      bgen_reg   <= 1'b0;
      refsel_reg <= 1'b0;
      div_reg    <= 3'h0;
      pin_en_reg <= `ADCCTL_RST_PIN_EN;
    end else if (wr_pend_reg) begin
      case (addr_reg)
        `ADCCTL_OFS_CTRL_A: begin
          start_reg <= wbyte[`ADCCTL_A_START];
          pdown_reg <= wbyte[`ADCCTL_A_PDOWN];
          align_reg <= wbyte[`ADCCTL_A_ALIGN];
          chan_reg  <= wbyte[`ADCCTL_A_CHAN_HI:0];
        end
        `ADCCTL_OFS_CTRL_B: begin
          bgsel_reg  <= wbyte[`ADCCTL_B_BGSEL];
          bgen_reg   <= wbyte[`ADCCTL_B_BGEN];
          refsel_reg <= wbyte[`ADCCTL_B_REFSEL];
          div_reg    <= wbyte[`ADCCTL_B_DIV_HI:0];
        end
        `ADCCTL_OFS_PIN_EN: pin_en_reg <= wbyte;
        default: pin_en_reg <= pin_en_reg;
      endcase
    end
  end

  // Busy flag and start sequencing
  // Only a completed conversion clears busy: an abort by power-down or by
  // a new start leaves it high, so a poll never mistakes an abort for a result.
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      busy_reg       <= 1'b1;
      conv_go_reg    <= 1'b0;
      ADC_CORE_RESET <= 1'b0;
    end else begin
      conv_go_reg <= start_fall && !pdown_reg;
      ADC_CORE_RESET <= wr_a ? wbyte[`ADCCTL_A_START] : start_reg;
      if (start_rise) begin
        busy_reg <= 1'b1;
      end else if (conv_done) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // A clear written in the cycle a conversion ends loses, so no end is missed
  // sticky end flag, set wins over clear
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      done_flag_reg <= 1'b0;
    end else if (conv_done) begin
      done_flag_reg <= 1'b1;
    end else if (wr_st && wbyte[`ADCCTL_S_DONE]) begin
      done_flag_reg <= 1'b0;
    end
  end
  assign CONV_DONE_FLAG = done_flag_reg;

  // Comparator crosses from the analog core; changes count once stages 2 and 3 agree
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      comp_s1_reg <= 1'b0;
      comp_s2_reg <= 1'b0;
      comp_s3_reg <= 1'b0;
      comp_reg    <= 1'b0;
    end else begin
      comp_s1_reg <= ADC_COMP_IN;
      comp_s2_reg <= comp_s1_reg;
      comp_s3_reg <= comp_s2_reg;
      if (comp_s2_reg == comp_s3_reg) begin
        comp_reg <= comp_s3_reg;
      end
    end
  end

  // Use the agreed level as soon as stages 2 and 3 match; comp_reg only
  // bridges a cycle in which they differ. This saves a cycle of latency, so
  // a converter clock of four system clocks still sees each trial's answer.
  assign comp_hi = (comp_s2_reg == comp_s3_reg) ? comp_s3_reg : comp_reg;

  // Code 8 is the current-sense amplifier and code 9 the bandgap;
  // in use means enabled and powered, the select bit is not required
  // pin and current sense routing
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ADC_CH_SEL <= 4'h0;
      BANDGAP_ON <= 1'b0;
      PULLUP_EN  <= 8'h00;
    end else begin
      if (bgsel_reg) begin
        ADC_CH_SEL <= `ADCCTL_CH_BANDGAP;
      end else if (chan_reg[3]) begin
        ADC_CH_SEL <= `ADCCTL_CH_CSENSE;
      end else begin
        ADC_CH_SEL <= {1'b0, chan_reg[2:0]};
      end
      // Supervisors keep the bandgap up even while the converter is off
      BANDGAP_ON <= bg_in_use || LVR_EN || LVD_EN;
      PULLUP_EN  <= PULLUP_REQ & ~pin_en_reg;
    end
  end
  assign bg_in_use = bgen_reg && !pdown_reg;

  assign PIN_ANALOG_EN = pin_en_reg;
  assign ADC_POWER_DOWN = pdown_reg;
  assign REF_EXT_SEL = refsel_reg;

  // Restarting with each go makes the first converter clock a whole period
  adcctl_clkdiv u_clkdiv (
    .clk      (MCLK),
    .rst_n    (RST_N),
    .restart  (conv_go_reg),
    .div_code (div_reg),
    .tick     (tick)
  );

  // A held start bit or power-down keeps the sequencer idle and aborts a run
  // high then low starts
  adcctl_sar #(
    .WIDTH (12)
  ) u_sar (
    .clk        (MCLK),
    .rst_n      (RST_N),
    .conv_reset (ADC_CORE_RESET || pdown_reg),
    .conv_go    (conv_go_reg),
    .tick       (tick),
    .comp_hi    (comp_hi),
    .sampling   (ADC_SAMPLE),
    .trial_code (ADC_DAC_CODE),
    .result     (result),
    .done       (conv_done)
  );

endmodule

// ### logic/adcctl_map.vh
// Register map, field positions, reset values and counts of the ADC control block.
// Included by adcctl_top and adcctl_sar (adcctl_clkdiv does not include it); definitions only.
`ifndef ADCCTL_MAP_VH
`define ADCCTL_MAP_VH

// Byte offsets of the word-aligned registers on the AHB-Lite bus
`define ADCCTL_OFS_RES_LO   8'h00
`define ADCCTL_OFS_RES_HI   8'h04
`define ADCCTL_OFS_CTRL_A   8'h08
`define ADCCTL_OFS_CTRL_B   8'h0c
`define ADCCTL_OFS_PIN_EN   8'h10
`define ADCCTL_OFS_STATUS   8'h14

// converter_control_a fields
`define ADCCTL_A_START      7
`define ADCCTL_A_BUSY       6
`define ADCCTL_A_PDOWN      5
`define ADCCTL_A_ALIGN      4
`define ADCCTL_A_CHAN_HI    3

// converter_control_b fields
`define ADCCTL_B_BGSEL      7
`define ADCCTL_B_BGEN       6
`define ADCCTL_B_REFSEL     4
`define ADCCTL_B_DIV_HI     2
`define ADCCTL_B_WMASK      8'hd7

// status register field
`define ADCCTL_S_DONE       0

// Reset values
`define ADCCTL_RST_CTRL_A   8'h60
`define ADCCTL_RST_CTRL_B   8'h00
`define ADCCTL_RST_PIN_EN   8'hff

// Channel codes presented to the analog multiplexer
`define ADCCTL_CH_CSENSE    4'h8
`define ADCCTL_CH_BANDGAP   4'h9

// Converter clock periods spent sampling before the first bit trial
`define ADCCTL_SAMPLE_TICKS 4'h2

`endif

// ### logic/adcctl_clkdiv.v
// Converter clock divider: one-cycle tick every 2**code system clocks.
// Assumes the code is stable during a conversion; restart realigns the phase.
`timescale 1ns/1ns
module adcctl_clkdiv (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Control
  input  wire       restart,
  input  wire [2:0] div_code,
  // Converter clock enable
  output reg        tick
);

  reg  [6:0] cnt_reg;
  reg  [6:0] cnt_next;
  wire [6:0] last;

  // Code 111 has no defined ratio; it runs at /128 rather than stalling
  assign last = (7'h01 << div_code) - 7'h01;

  always @* begin
    if (restart || cnt_reg >= last) begin
      cnt_next = 7'h00;
    end else begin
      cnt_next = cnt_reg + 7'h01;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 7'h00;
      tick    <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick    <= !restart && cnt_reg >= last;
    end
  end

endmodule

// ### logic/adcctl_sar.v
// Successive-approximation sequencer: sample phase, then twelve bit trials.
// Assumes the analog core compares the held input against the trial code.
`timescale 1ns/1ns
`include "adcctl_map.vh"
module adcctl_sar #(
  parameter WIDTH = 12
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // Sequencing
  input  wire             conv_reset,
  input  wire             conv_go,
  input  wire             tick,
  input  wire             comp_hi,
  // Analog core side
  output reg              sampling,
  output reg  [WIDTH-1:0] trial_code,
  // Result
  output reg  [WIDTH-1:0] result,
  output reg              done
);

  localparam ST_IDLE   = 2'd0;
  localparam ST_SAMPLE = 2'd1;
  localparam ST_TRIAL  = 2'd2;

  reg [1:0]       state_reg;
  reg [3:0]       cnt_reg;
  reg [WIDTH-1:0] bit_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= ST_IDLE;
      cnt_reg    <= 4'h0;
      bit_reg    <= {WIDTH{1'b0}};
      sampling   <= 1'b0;
      trial_code <= {WIDTH{1'b0}};
      result     <= {WIDTH{1'b0}};
      done       <= 1'b0;
    end else begin
      done <= 1'b0;
      if (conv_reset) begin
        state_reg  <= ST_IDLE;
        sampling   <= 1'b0;
        trial_code <= {WIDTH{1'b0}};
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (conv_go) begin
              state_reg <= ST_SAMPLE;
              sampling  <= 1'b1;
              cnt_reg   <= 4'h0;
            end
          end
          ST_SAMPLE: begin
            if (tick) begin
              if (cnt_reg == `ADCCTL_SAMPLE_TICKS - 4'h1) begin
                state_reg  <= ST_TRIAL;
                sampling   <= 1'b0;
                bit_reg    <= {1'b1, {(WIDTH-1){1'b0}}};
                trial_code <= {1'b1, {(WIDTH-1){1'b0}}};
              end else begin
                cnt_reg <= cnt_reg + 4'h1;
              end
            end
          end
          ST_TRIAL: begin
            if (tick) begin
              // Drop the trial bit when the input lies below the trial level
              if (bit_reg[0]) begin
                result    <= comp_hi ? trial_code : (trial_code & ~bit_reg);
                done      <= 1'b1;
                state_reg <= ST_IDLE;
              end else begin
                trial_code <= (comp_hi ? trial_code : (trial_code & ~bit_reg)) | (bit_reg >> 1);
              end
              bit_reg <= bit_reg >> 1;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// ### tb/adcctl_asserts.sv
// Concurrent checks on the ports of the ADC control block.
// Bound into adcctl_top; sees nothing but its ports.
`timescale 1ns/1ns
`include "adcctl_map.vh"
module adcctl_chk (
  // Clock and reset
  input logic        MCLK,
  input logic        RST_N,
  // Bus
  input logic        HSEL,
  input logic [31:0] HADDR,
  input logic [1:0]  HTRANS,
  input logic        HWRITE,
  input logic        HREADY,
  input logic        HREADYOUT,
  // Converter
  input logic        ADC_SAMPLE,
  input logic        ADC_CORE_RESET,
  input logic        ADC_POWER_DOWN,
  input logic [3:0]  ADC_CH_SEL,
  input logic        CONV_DONE_FLAG,
  // Bandgap and pins
  input logic        LVR_EN,
  input logic        LVD_EN,
  input logic        BANDGAP_ON,
  input logic [7:0]  PULLUP_REQ,
  input logic [7:0]  PIN_ANALOG_EN,
  input logic [7:0]  PULLUP_EN
);
  reg clr_reg;
  // A status write with bit 0 set clears the flag at the end of its data phase
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N)
      clr_reg <= 1'b0;
    else
      clr_reg <= HSEL && HREADY && HTRANS[1] && HWRITE && HADDR[7:0] == `ADCCTL_OFS_STATUS;
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  a_pullup_drop: assert property (PULLUP_EN == ($past(PULLUP_REQ) & ~$past(PIN_ANALOG_EN)))
    else $error("pull-up left on an analog pin");
  a_bandgap_idle: assert property (!$past(LVR_EN) && !$past(LVD_EN) && $past(ADC_POWER_DOWN) |-> !BANDGAP_ON)
    else $error("bandgap on while unused");
  a_read_wait: assert property (HSEL && HREADY && HTRANS[1] && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state wrong");
  a_write_nowait: assert property (HSEL && HREADY && HTRANS[1] && HWRITE |=> HREADYOUT)
    else $error("write stalled");
  a_chan_range: assert property (ADC_CH_SEL <= 4'h9)
    else $error("channel code out of range");
  a_sample_powered: assert property ($rose(ADC_SAMPLE) |-> !ADC_POWER_DOWN)
    else $error("sampling while powered down");
  a_reset_holds: assert property (ADC_CORE_RESET && $past(ADC_CORE_RESET) |-> !ADC_SAMPLE)
    else $error("sampling during core reset");
  a_flag_sticky: assert property (CONV_DONE_FLAG && !clr_reg |=> CONV_DONE_FLAG)
    else $error("done flag dropped without clear");
  a_done_quiet: assert property ($rose(CONV_DONE_FLAG) |-> !ADC_SAMPLE && !ADC_CORE_RESET)
    else $error("done raised mid conversion");
endmodule

bind adcctl_top adcctl_chk adcctl_chk_i (
  .MCLK(MCLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .ADC_SAMPLE(ADC_SAMPLE),
  .ADC_CORE_RESET(ADC_CORE_RESET), .ADC_POWER_DOWN(ADC_POWER_DOWN), .ADC_CH_SEL(ADC_CH_SEL),
  .CONV_DONE_FLAG(CONV_DONE_FLAG), .LVR_EN(LVR_EN), .LVD_EN(LVD_EN), .BANDGAP_ON(BANDGAP_ON),
  .PULLUP_REQ(PULLUP_REQ), .PIN_ANALOG_EN(PIN_ANALOG_EN), .PULLUP_EN(PULLUP_EN)
);

// ### tb/adcctl_core_model.sv
// Behavioural analog core: source multiplexer, sample-and-hold, comparator.
// Assumes trial codes step no faster than one per four clocks.
`timescale 1ns/1ns
module adcctl_core (
  // Clock
  input  wire         clk,
  // Control from the block
  input  wire [11:0]  dac_code,
  input  wire         sample,
  input  wire         pdown,
  input  wire [3:0]   ch_sel,
  // One 12-bit level a channel, channel 9 the bandgap
  input  wire [119:0] levels,
  // Comparator
  output reg          comp
);
  reg [11:0] held = 12'h000;
  reg        tog = 1'b0;
  always @(posedge clk) begin
    if (sample)
      held <= levels[ch_sel*12 +: 12];
    tog <= ~tog;
  end
  always @* begin
    comp = pdown ? tog : (held >= dac_code);
  end
endmodule

// ### tb/test_adc_control_and_result_regs.sv
// Self-checking bench for the ADC control block.
// Assumes the map header and the analog core model beside it.
`timescale 1ns/1ns
`include "adcctl_map.vh"
module test_adc_control_and_result_regs;
  localparam [7:0] R_LO = `ADCCTL_OFS_RES_LO;
  localparam [7:0] R_HI = `ADCCTL_OFS_RES_HI;
  localparam [7:0] R_A = `ADCCTL_OFS_CTRL_A;
  localparam [7:0] R_B = `ADCCTL_OFS_CTRL_B;
  localparam [7:0] R_PE = `ADCCTL_OFS_PIN_EN;
  localparam [7:0] R_ST = `ADCCTL_OFS_STATUS;
  localparam int   BG_SETTLE = 20;
  reg          mclk = 1'b0;
  reg          rst_n = 1'b0;
  reg  [31:0]  haddr = 32'h0;
  reg  [31:0]  hwdata = 32'h0;
  reg  [1:0]   htrans = 2'b00;
  reg          hwrite = 1'b0;
  reg          lvr_en = 1'b0;
  reg          lvd_en = 1'b0;
  reg  [7:0]   pullup_req = 8'hff;
  reg  [119:0] levels = {12'h4e2, 12'h5f1, 48'h0, 12'habc, 24'h0, 12'h39d};
  wire [31:0]  hrdata;
  wire [11:0]  dac_code;
  wire [3:0]   ch_sel;
  wire [7:0]   pin_an;
  wire [7:0]   pullup_en;
  wire         hreadyout, comp, sample, core_rst, pdown, ref_ext, bg_on, done_flag;
  int          miscompares = 0;
  int          checks_done = 0;

  adcctl_top adcctl_top_i (
    .MCLK(mclk), .RST_N(rst_n), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(), .ADC_COMP_IN(comp),
    .ADC_DAC_CODE(dac_code), .ADC_SAMPLE(sample), .ADC_CORE_RESET(core_rst),
    .ADC_POWER_DOWN(pdown), .ADC_CH_SEL(ch_sel), .REF_EXT_SEL(ref_ext),
    .LVR_EN(lvr_en), .LVD_EN(lvd_en), .BANDGAP_ON(bg_on), .PULLUP_REQ(pullup_req),
    .PIN_ANALOG_EN(pin_an), .PULLUP_EN(pullup_en), .CONV_DONE_FLAG(done_flag)
  );

  adcctl_core adcctl_core_i (
    .clk(mclk), .dac_code(dac_code), .sample(sample), .pdown(pdown),
    .ch_sel(ch_sel), .levels(levels), .comp(comp)
  );

  initial begin
    forever #25 mclk = ~mclk;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic hang;
    miscompares++;
    $display("[ERR] %0t wait ran out", $time);
    conclude();
  endtask

  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmpw(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("[ERR] %0t length %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Ready and read data are looked at on the falling edge, where they are
  // settled, and the transfer moves on at the rising edge that follows
  task automatic rdy(output logic [31:0] q);
    int n;
    logic r;
    n = 0;
    do begin
      @(negedge mclk);
      r = hreadyout;
      q = hrdata;
      @(posedge mclk);
      n++;
    end while (r !== 1'b1 && n < 20);
    if (r !== 1'b1) hang();
  endtask

  // Address phase held until ready, then data phase until ready again
  task automatic bus(input bit w, input [7:0] a, input [7:0] d, output logic [7:0] q);
    logic [31:0] rw;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    rdy(rw);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    rdy(rw);
    q = rw[7:0];
  endtask

  task automatic wr(input [7:0] a, input [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_cmp(input [7:0] a, input [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    cmp({4'h0, q}, {4'h0, e});
  endtask

  task automatic conv(input [7:0] a, output int len);
    wr(R_A, a | 8'h80);
    rd_cmp(R_A, a | 8'hc0);
    cmp(12'(core_rst), 12'h001);
    wr(R_A, a);
    len = 0;
    do begin
      @(negedge mclk);
      len++;
    end while (done_flag !== 1'b1 && len < 4000);
    if (done_flag !== 1'b1) hang();
    @(posedge mclk);
    rd_cmp(R_A, a);
    wr(R_ST, 8'h01);
    tick(2);
    cmp(12'(done_flag), 12'h000);
  endtask

  task automatic t_reset;
    rd_cmp(R_A, 8'h60);
    rd_cmp(R_B, 8'h00);
    rd_cmp(R_PE, 8'hff);
    rd_cmp(R_LO, 8'h00);
    rd_cmp(R_HI, 8'h00);
    rd_cmp(8'h18, 8'h00);
    cmp(12'(pullup_en), 12'h000);
  endtask

  task automatic t_regs;
    wr(R_B, 8'hff);
    rd_cmp(R_B, 8'hd7);
    cmp(12'(ref_ext), 12'h001);
    wr(R_B, 8'h00);
    tick(2);
    cmp(12'(ref_ext), 12'h000);
    wr(R_PE, 8'ha5);
    rd_cmp(R_PE, 8'ha5);
    cmp(12'(pin_an), 12'h0a5);
    cmp(12'(pullup_en), 12'h05a);
    wr(R_LO, 8'hff);
    rd_cmp(R_LO, 8'h00);
    wr(8'h18, 8'hff);
    rd_cmp(8'h18, 8'h00);
    wr(R_A, 8'h20);
    rd_cmp(R_A, 8'h60);
  endtask

  task automatic t_chan;
    for (int c = 0; c < 16; c++) begin
      wr(R_A, 8'h20 | 8'(c));
      tick(2);
      cmp(12'(ch_sel), (c < 8) ? 12'(c) : 12'h008);
    end
    cmp(12'(pdown), 12'h001);
    wr(R_B, 8'hc0);
    tick(2);
    cmp(12'(ch_sel), 12'h009);
    cmp(12'(bg_on), 12'h000);
    wr(R_A, 8'h00);
    tick(2);
    cmp(12'(bg_on), 12'h001);
    cmp(12'(done_flag), 12'h000);
    wr(R_B, 8'h00);
    lvr_en <= 1'b1;
    tick(2);
    cmp(12'(bg_on), 12'h001);
    lvr_en <= 1'b0;
    lvd_en <= 1'b1;
    tick(2);
    cmp(12'(bg_on), 12'h001);
    lvd_en <= 1'b0;
    tick(2);
    cmp(12'(bg_on), 12'h000);
  endtask

  task automatic t_refuse;
    wr(R_A, 8'ha0);
    rd_cmp(R_A, 8'he0);
    wr(R_A, 8'h20);
    tick(60);
    rd_cmp(R_A, 8'h60);
    cmp(12'(done_flag), 12'h000);
  endtask

  task automatic t_conv;
    int n;
    // divide by 16 gives an 800 ns converter clock
    wr(R_B, 8'h04);
    conv(8'h03, n);
    rd_cmp(R_HI, 8'hab);
    rd_cmp(R_LO, 8'hc0);
    wr(R_A, 8'h13);
    rd_cmp(R_HI, 8'h0a);
    rd_cmp(R_LO, 8'hbc);
    conv(8'h18, n);
    rd_cmp(R_HI, 8'h05);
    rd_cmp(R_LO, 8'hf1);
    wr(R_B, 8'h44);
    tick(BG_SETTLE);
    wr(R_B, 8'hc4);
    conv(8'h00, n);
    rd_cmp(R_HI, 8'h4e);
    rd_cmp(R_LO, 8'h20);
  endtask

  task automatic t_div;
    int n;
    int m;
    for (int c = 0; c < 8; c++) begin
      wr(R_B, 8'(c));
      conv(8'h00, n);
      cmpw(n, 14 << c, (16 << c) + 8);
      if (c >= 2) rd_cmp(R_HI, 8'h39);
    end
    conv(8'h00, m);
    cmp(12'(m), 12'(n));
    wr(R_A, 8'h40);
    rd_cmp(R_A, 8'h00);
    wr(R_A, 8'h20);
  endtask

  initial begin
    tick(8);
    rst_n <= 1'b1;
    tick(1);
    t_reset();
    t_regs();
    t_chan();
    t_refuse();
    t_conv();
    t_div();
    conclude();
  end
endmodule
